// [hw/aux_clock_control.v]
// aux clock output and pll pin override control with its serial register port
//
// Contract
// - aux_output_control bit 7 disables (0) or enables (1) the aux output buffer and divider.
// - aux select 0, 1, 2 give a 16, 32, 64 UI clock; values 4 to 7 are reserved.
// - aux select 3 drives the aux output with the internally resampled timestamp input.
// - override bit 7 chooses pin control (0) or register control (1) of the pll.
// - the D select field steers output D only under override, else the config pins do.
// - D select 0 disables output D; 1, 2, 3 give the pll reference divided by 1, 2, 4.
// - output D never carries a clock unless output C carries one too.
// - the C select field steers output C only under override, else the config pins do.
// - C select 0 disables output C; 1, 2, 3 give the pll reference divided by 1, 2, 4.
// - under override bit 1 replaces the single-ended reference pin.
// - under override bit 0 replaces the pll enable pin.
`timescale 1ns/1ps
`default_nettype none
`include "aux_clock_map.vh"

module aux_clock_control (
    input  wire       ref_clk,             // 10 MHz register clock
    input  wire       reset_n,             // async reset, active low
    input  wire       spi_sclk,            // serial port clock pin
    input  wire       spi_cs_n,            // serial port select pin, active low
    input  wire       spi_sdi,             // serial data in pin
    output reg        spi_sdo,             // serial data out
    output reg        spi_sdo_oe,          // high while sdo is driven
    input  wire       ui_tick,             // serializer pulse, one per UI
    input  wire       serializer_reinit,   // high while serializer restarts
    input  wire       timestamp_input,     // timestamp pin
    input  wire       ref_half_tick,       // pulse per pll reference half period
    input  wire       pll_enable_pin,      // pll enable config pin
    input  wire       single_ended_ref_pin,// single-ended reference config pin
    input  wire       clock_config_pin_a,  // clock config pin, low bit
    input  wire       clock_config_pin_b,  // clock config pin, high bit
    output wire       aux_out_pin,         // aux output
    output wire       aux_out_enable,      // aux buffer/divider powered
    output wire       pll_enable,          // effective pll enable
    output wire       single_ended_ref_clock, // effective single-ended ref select
    output wire       ref_out_c_pin,       // divided reference output C
    output wire       ref_out_d_pin        // divided reference output D
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_HEAD = 3'b010;
    localparam ST_DATA = 3'b100;

    reg  [7:0]  aux_output_control;
    reg  [7:0]  pll_pin_override;
    reg  [2:0]  state;
    reg  [4:0]  bit_cnt;
    reg  [15:0] header;
    reg  [7:0]  wr_shift;
    reg  [7:0]  rd_shift;
    reg  [2:0]  sclk_sync, cs_sync, sdi_sync, ts_sync, pen_sync, se_sync, cfa_sync, cfb_sync;
    reg         sclk_lvl, cs_lvl, ts_lvl, pen_lvl, se_lvl, cfa_lvl, cfb_lvl;
    reg         aux_mux;
    reg  [6:0]  aux_half;
    wire        sclk_rise, sclk_fall, frame_on;
    wire [1:0]  c_sel, d_sel;
    wire [2:0]  aux_sel;
    wire        aux_div_clk, c_clk, d_clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // register readback; unmapped addresses read zero
    function [7:0] read_reg;
        input [14:0] addr;
        input [7:0]  aux_v;
        input [7:0]  ovr_v;
        begin
            if (addr == `ADDR_AUX_OUTPUT_CONTROL)
                read_reg = aux_v;
            else if (addr == `ADDR_PLL_PIN_OVERRIDE)
                read_reg = ovr_v;
            else
                read_reg = `UNMAPPED_READ_VALUE;
        end
    endfunction

    // half-period count for a reference divide select
    function [6:0] ref_half;
        input [1:0] sel;
        begin
            case (sel)
                `REF_SEL_DIV2: ref_half = `HALF_DIV2;
                `REF_SEL_DIV4: ref_half = `HALF_DIV4;
                default:       ref_half = `HALF_DIV1;
            endcase
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // three stages; a level moves only once stages two and three agree
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync <= 3'h0;
            cs_sync   <= 3'h7;
            sdi_sync  <= 3'h0;
            ts_sync   <= 3'h0;
            pen_sync  <= 3'h0;
            se_sync   <= 3'h0;
            cfa_sync  <= 3'h0;
            cfb_sync  <= 3'h0;
            sclk_lvl  <= 1'b0;
            cs_lvl    <= 1'b1;
            ts_lvl    <= 1'b0;
            pen_lvl   <= 1'b0;
            se_lvl    <= 1'b0;
            cfa_lvl   <= 1'b0;
            cfb_lvl   <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], spi_sclk};
            cs_sync   <= {cs_sync[1:0], spi_cs_n};
            sdi_sync  <= {sdi_sync[1:0], spi_sdi};
            ts_sync   <= {ts_sync[1:0], timestamp_input};
            pen_sync  <= {pen_sync[1:0], pll_enable_pin};
            se_sync   <= {se_sync[1:0], single_ended_ref_pin};
            cfa_sync  <= {cfa_sync[1:0], clock_config_pin_a};
            cfb_sync  <= {cfb_sync[1:0], clock_config_pin_b};
            if (sclk_sync[1] == sclk_sync[2]) sclk_lvl <= sclk_sync[2];
            if (cs_sync[1] == cs_sync[2])     cs_lvl   <= cs_sync[2];
            if (ts_sync[1] == ts_sync[2])     ts_lvl   <= ts_sync[2];
            if (pen_sync[1] == pen_sync[2])   pen_lvl  <= pen_sync[2];
            if (se_sync[1] == se_sync[2])     se_lvl   <= se_sync[2];
            if (cfa_sync[1] == cfa_sync[2])   cfa_lvl  <= cfa_sync[2];
            if (cfb_sync[1] == cfb_sync[2])   cfb_lvl  <= cfb_sync[2];
        end
    end

    assign sclk_rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_lvl;
    assign sclk_fall = (sclk_sync[1] == sclk_sync[2]) && !sclk_sync[2] && sclk_lvl;
    assign frame_on  = !cs_lvl;

    // ----------------------------------------
    // serial register port
    // ----------------------------------------
    // sclk must stay well below ref_clk/8 so each level survives the filter
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state              <= ST_IDLE;
            bit_cnt            <= 5'h00;
            header             <= 16'h0000;
            wr_shift           <= 8'h00;
            rd_shift           <= 8'h00;
            spi_sdo            <= 1'b0;
            spi_sdo_oe         <= 1'b0;
            aux_output_control <= `REG_RESET_VALUE;
            pll_pin_override   <= `REG_RESET_VALUE;
        end else if (!frame_on) begin
            state      <= ST_IDLE;
            bit_cnt    <= 5'h00;
            spi_sdo_oe <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    state   <= ST_HEAD;
                    bit_cnt <= 5'h00;
                end
                ST_HEAD: begin
                    if (sclk_rise) begin
                        header  <= {header[14:0], sdi_sync[2]};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt + 5'h01 == `HEADER_BITS) begin
                            state    <= ST_DATA;
                            rd_shift <= read_reg(header[13:0] == 14'h0000 && sdi_sync[2]
                                                 ? 15'h0001 : {header[13:0], sdi_sync[2]},
                                                 aux_output_control, pll_pin_override);
                        end
                    end
                end
                ST_DATA: begin
                    // read: shift data out on falling edges, msb first
                    if (sclk_fall && header[15] && bit_cnt < `FRAME_BITS) begin
                        spi_sdo    <= rd_shift[7];
                        spi_sdo_oe <= 1'b1;
                        rd_shift   <= {rd_shift[6:0], 1'b0};
                    end
                    if (sclk_rise && bit_cnt < `FRAME_BITS) begin
                        wr_shift <= {wr_shift[6:0], sdi_sync[2]};
                        bit_cnt  <= bit_cnt + 5'h01;
                        // write commits on the last bit; whole byte kept for readback
                        if (bit_cnt + 5'h01 == `FRAME_BITS && !header[15]) begin
                            if (header[14:0] == `ADDR_AUX_OUTPUT_CONTROL)
                                aux_output_control <= {wr_shift[6:0], sdi_sync[2]};
                            if (header[14:0] == `ADDR_PLL_PIN_OVERRIDE)
                                pll_pin_override <= {wr_shift[6:0], sdi_sync[2]};
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // aux output path
    // ----------------------------------------
    assign aux_out_enable = aux_output_control[`AUX_OUT_ENABLE_BIT];
    assign aux_sel = aux_output_control[`AUX_OUT_SELECT_MSB:`AUX_OUT_SELECT_LSB];

    // source pick; select is assumed steady while enabled, so no glitch-free mux
    always @* begin
        aux_half = `HALF_16UI;
        aux_mux  = 1'b0;
        case (aux_sel)
            `AUX_SEL_16UI: begin
                aux_half = `HALF_16UI;
                aux_mux  = aux_div_clk;
            end
            `AUX_SEL_32UI: begin
                aux_half = `HALF_32UI;
                aux_mux  = aux_div_clk;
            end
            `AUX_SEL_64UI: begin
                aux_half = `HALF_64UI;
                aux_mux  = aux_div_clk;
            end
            `AUX_SEL_TIMESTAMP: aux_mux = ts_lvl;
            default:            aux_mux = 1'b0;
        endcase
    end

    // serializer restart drops the divided clock and restarts its phase
    tick_divider aux_divider (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .tick       (ui_tick),
        .half_count (aux_half),
        .run        (aux_out_enable && !serializer_reinit),
        .clk_out    (aux_div_clk)
    );

    assign aux_out_pin = aux_out_enable && aux_mux;

    // ----------------------------------------
    // pll pin override
    // ----------------------------------------
    // register values only count while override is set
    assign pll_enable = pll_pin_override[`PLL_OVERRIDE_ENABLE_BIT]
                      ? pll_pin_override[`PLL_ENABLE_BIT] : pen_lvl;
    assign single_ended_ref_clock = pll_pin_override[`PLL_OVERRIDE_ENABLE_BIT]
                      ? pll_pin_override[`SINGLE_ENDED_REF_BIT] : se_lvl;
    assign c_sel = pll_pin_override[`PLL_OVERRIDE_ENABLE_BIT]
                 ? pll_pin_override[`REF_OUT_C_MSB:`REF_OUT_C_LSB]
                 : {cfb_lvl, cfa_lvl};
    assign d_sel = pll_pin_override[`PLL_OVERRIDE_ENABLE_BIT]
                 ? pll_pin_override[`REF_OUT_D_MSB:`REF_OUT_D_LSB]
                 : {cfb_lvl, cfa_lvl};

    tick_divider ref_c_divider (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .tick       (ref_half_tick),
        .half_count (ref_half(c_sel)),
        .run        (c_sel != `REF_SEL_OFF),
        .clk_out    (c_clk)
    );

    // d is held off whenever c is off
    tick_divider ref_d_divider (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .tick       (ref_half_tick),
        .half_count (ref_half(d_sel)),
        .run        (d_sel != `REF_SEL_OFF && c_sel != `REF_SEL_OFF),
        .clk_out    (d_clk)
    );

    assign ref_out_c_pin = c_clk;
    assign ref_out_d_pin = d_clk;

endmodule

`default_nettype wire

// [hw/aux_clock_map.vh]
// register map, field positions, codes and counts of the aux clock / pll override block
`ifndef AUX_CLOCK_MAP_VH
`define AUX_CLOCK_MAP_VH

// ----------------------------------------
// register addresses (15-bit serial address)
// ----------------------------------------
`define ADDR_AUX_OUTPUT_CONTROL 15'h0057
`define ADDR_PLL_PIN_OVERRIDE   15'h0058
`define REG_RESET_VALUE         8'h00
`define UNMAPPED_READ_VALUE     8'h00

// ----------------------------------------
// aux_output_control fields
// ----------------------------------------
`define AUX_OUT_ENABLE_BIT      7
`define AUX_OUT_SELECT_MSB      2
`define AUX_OUT_SELECT_LSB      0
`define AUX_SEL_16UI            3'h0
`define AUX_SEL_32UI            3'h1
`define AUX_SEL_64UI            3'h2
`define AUX_SEL_TIMESTAMP       3'h3

// ----------------------------------------
// pll_pin_override fields
// ----------------------------------------
`define PLL_OVERRIDE_ENABLE_BIT 7
`define REF_OUT_D_MSB           5
`define REF_OUT_D_LSB           4
`define REF_OUT_C_MSB           3
`define REF_OUT_C_LSB           2
`define SINGLE_ENDED_REF_BIT    1
`define PLL_ENABLE_BIT          0
`define REF_SEL_OFF             2'h0
`define REF_SEL_DIV1            2'h1
`define REF_SEL_DIV2            2'h2
`define REF_SEL_DIV4            2'h3

// ----------------------------------------
// divider half-period counts, in input ticks
// ----------------------------------------
`define HALF_16UI               7'h08
`define HALF_32UI               7'h10
`define HALF_64UI               7'h20
`define HALF_DIV1               7'h01
`define HALF_DIV2               7'h02
`define HALF_DIV4               7'h04

// ----------------------------------------
// serial frame layout: rw bit, 15 address bits, 8 data bits
// ----------------------------------------
`define FRAME_BITS              5'h18
`define HEADER_BITS             5'h10

`endif

// [hw/tick_divider.v]
// tick-driven clock divider that toggles its output every programmed number of ticks
`timescale 1ns/1ps
`default_nettype none

module tick_divider (
    input  wire       ref_clk,     // block clock
    input  wire       reset_n,     // async reset, active low
    input  wire       tick,        // one-cycle pulse per source event
    input  wire [6:0] half_count,  // ticks per output half period
    input  wire       run,         // low holds the output low
    output reg        clk_out      // divided clock, registered
);

    reg [6:0] count;

    // ----------------------------------------
    // divider core
    // ----------------------------------------
    // restarting from zero on stop keeps the first period after enable whole
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count   <= 7'h00;
            clk_out <= 1'b0;
        end else if (!run) begin
            count   <= 7'h00;
            clk_out <= 1'b0;
        end else if (tick) begin
            if (count + 7'h01 >= half_count) begin
                count   <= 7'h00;
                clk_out <= ~clk_out;
            end else begin
                count <= count + 7'h01;
            end
        end
    end

endmodule

`default_nettype wire

// [sim/aux_clock_chk.sv]
// concurrent checks on the ports of the aux clock / pll override block
`timescale 1ns/1ps
`default_nettype none

module aux_clock_chk (
    input wire logic ref_clk,                // block clock
    input wire logic reset_n,                // async reset, active low
    input wire logic spi_sclk,               // serial clock pin
    input wire logic spi_cs_n,               // frame select, active low
    input wire logic spi_sdo,                // serial read data
    input wire logic spi_sdo_oe,             // read data driven
    input wire logic serializer_reinit,      // serializer restart
    input wire logic timestamp_input,        // timestamp pin
    input wire logic aux_out_pin,            // aux output
    input wire logic aux_out_enable,         // aux buffer powered
    input wire logic pll_enable,             // effective pll enable
    input wire logic single_ended_ref_clock, // effective ref select
    input wire logic ref_out_c_pin,          // divided reference C
    input wire logic ref_out_d_pin           // divided reference D
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ---------------------------------------------
    // helper counters
    // ---------------------------------------------
    logic [3:0] d_runs; // D edges since C last moved; a stopped C lets this climb
    logic [2:0] ts_low; // cycles the timestamp pin stayed low, saturating
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            d_runs <= 4'h0;
            ts_low <= 3'h0;
        end else begin
            if (ref_out_c_pin != $past(ref_out_c_pin)) d_runs <= 4'h0;
            else if (ref_out_d_pin != $past(ref_out_d_pin) && d_runs != 4'hF) d_runs <= d_runs + 4'h1;
            ts_low <= timestamp_input ? 3'h0 : (ts_low == 3'h7 ? 3'h7 : ts_low + 3'h1);
        end
    end

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    a_reset_all_low: assert property (disable iff (1'b0) !reset_n ##1 !reset_n |->
        !aux_out_enable && !aux_out_pin && !pll_enable && !single_ended_ref_clock
        && !ref_out_c_pin && !ref_out_d_pin) else $error("outputs not low in reset");
    a_aux_gate_off: assert property (!aux_out_enable |-> !aux_out_pin)
        else $error("aux output active while disabled");
    a_enable_by_write: assert property ($changed(aux_out_enable) |-> !$past(spi_cs_n))
        else $error("aux enable moved outside a frame");
    a_d_needs_c: assert property ($changed(ref_out_d_pin) |-> d_runs <= 4'h8)
        else $error("output D runs while C is still");
    a_reinit_drops_aux: assert property (serializer_reinit [*3] ##0 ts_low == 3'h7
        |-> !aux_out_pin) else $error("aux output kept running in reinit");
    a_sdo_released: assert property (spi_cs_n [*8] |-> !spi_sdo_oe)
        else $error("read data driven outside a frame");
    a_oe_in_frame: assert property ($rose(spi_sdo_oe) |-> !spi_cs_n)
        else $error("read data enabled without select");
    a_sdo_on_fall: assert property (spi_sdo_oe && $changed(spi_sdo) |-> !$past(spi_sclk))
        else $error("read data moved while clock high");

    c_aux_runs: cover property (aux_out_enable && $rose(aux_out_pin));
    c_read_data: cover property ($rose(spi_sdo_oe));
    c_d_runs: cover property ($changed(ref_out_d_pin));
endmodule

bind aux_clock_control aux_clock_chk u_chk (.ref_clk, .reset_n, .spi_sclk, .spi_cs_n,
    .spi_sdo, .spi_sdo_oe, .serializer_reinit, .timestamp_input, .aux_out_pin,
    .aux_out_enable, .pll_enable, .single_ended_ref_clock, .ref_out_c_pin, .ref_out_d_pin);

`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the aux clock output and pll override block
`timescale 1ns/1ps
`default_nettype none
`include "aux_clock_map.vh"
`define CHECK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, a); end end

module testbench;
    logic ref_clk = 0, reset_n = 0, spi_sclk = 0, spi_cs_n = 1, spi_sdi = 0, ui_tick = 1;
    logic serializer_reinit = 0, timestamp_input = 0, ref_half_tick = 0;
    logic pll_enable_pin = 0, single_ended_ref_pin = 0;
    logic clock_config_pin_a = 0, clock_config_pin_b = 0;
    wire  spi_sdo, spi_sdo_oe, aux_out_pin, aux_out_enable, pll_enable;
    wire  single_ended_ref_clock, ref_out_c_pin, ref_out_d_pin;
    int          bad_count = 0, num_checks = 0, seed = 54;
    logic [7:0]  exp_q[$], rd_val, res, e, v, per;
    string       nm_q[$], nm;
    event        res_ev;

    aux_clock_control dut (.ref_clk, .reset_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
        .spi_sdo_oe, .ui_tick, .serializer_reinit, .timestamp_input, .ref_half_tick,
        .pll_enable_pin, .single_ended_ref_pin, .clock_config_pin_a, .clock_config_pin_b,
        .aux_out_pin, .aux_out_enable, .pll_enable, .single_ended_ref_clock,
        .ref_out_c_pin, .ref_out_d_pin);

    // ---------------------------------------------
    // clock, tick sources and scoreboard
    // ---------------------------------------------
    always #50 ref_clk = ~ref_clk;
    // reference half-period pulse every other cycle, so div N gives a 4N-cycle period
    always @(negedge ref_clk) ref_half_tick <= ~ref_half_tick;
    // oldest note is matched against each result as it appears
    always @(res_ev) begin
        nm = nm_q.pop_front();
        e = exp_q.pop_front();
        `CHECK(nm, e, res)
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic note(input string s, input logic [7:0] x);
        nm_q.push_back(s);
        exp_q.push_back(x);
    endtask
    task automatic seen(input logic [7:0] r);
        res = r;
        -> res_ev;
        #1;
    endtask
    // one 24-bit frame; 8-cycle sclk halves leave room for the 3-flop filter
    task automatic frame(input logic rw, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] bits;
        bits = {rw, a, d};
        spi_cs_n = 0;
        for (int i = 0; i < 24; i++) begin
            spi_sdi = bits[23 - i];
            cyc(8);
            if (i >= 16) rd_val = {rd_val[6:0], spi_sdo};
            spi_sclk = 1;
            cyc(8);
            spi_sclk = 0;
        end
        cyc(8);
        spi_cs_n = 1;
        cyc(8);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] x);
        note("readback", x);
        frame(1'b1, a, 8'h00);
        seen(rd_val);
        note("sdo released", 8'h00);
        seen({7'h00, spi_sdo_oe});
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? aux_out_pin : (w == 1 ? ref_out_c_pin : ref_out_d_pin);
    endfunction
    // cycles between two rising edges of an output, 0 if it never rises twice
    task automatic period(input int w, output logic [7:0] n);
        logic prev;
        int   rises;
        n = 8'h00;
        rises = 0;
        prev = pick(w);
        for (int i = 0; i < 300 && rises < 2; i++) begin
            cyc(1);
            if (rises == 1) n = n + 8'h01;
            if (pick(w) && !prev) rises++;
            prev = pick(w);
        end
        if (rises < 2) n = 8'h00;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        cyc(6);
        reset_n = 1;
        cyc(6);
        rd(`ADDR_AUX_OUTPUT_CONTROL, `REG_RESET_VALUE);
        rd(`ADDR_PLL_PIN_OVERRIDE, `REG_RESET_VALUE);
        // random values, reserved bits kept zero and aux disabled
        for (int k = 0; k < 3; k++) begin
            v = 8'($random(seed));
            frame(1'b0, `ADDR_AUX_OUTPUT_CONTROL, {5'h00, v[2:0]});
            rd(`ADDR_AUX_OUTPUT_CONTROL, {5'h00, v[2:0]});
            frame(1'b0, `ADDR_PLL_PIN_OVERRIDE, {2'h0, v[5:0]});
            rd(`ADDR_PLL_PIN_OVERRIDE, {2'h0, v[5:0]});
        end
        rd(15'h0059, `UNMAPPED_READ_VALUE);
        // aux selects 0 to 4: divided clocks, timestamp and reserved; select changed only while disabled
        for (int s = 0; s < 5; s++) begin
            frame(1'b0, `ADDR_AUX_OUTPUT_CONTROL, s[7:0]);
            frame(1'b0, `ADDR_AUX_OUTPUT_CONTROL, 8'h80 | s[7:0]);
            note("aux enable", 8'h01);
            seen({7'h00, aux_out_enable});
            if (s == 3) begin
                timestamp_input = 1;
                cyc(6);
                note("aux timestamp", 8'h01);
                seen({7'h00, aux_out_pin});
                timestamp_input = 0;
                cyc(6);
                note("aux timestamp", 8'h00);
                seen({7'h00, aux_out_pin});
            end else begin
                period(0, per);
                note("aux period", s < 3 ? 8'd16 << s : 8'h00);
                seen(per);
            end
            frame(1'b0, `ADDR_AUX_OUTPUT_CONTROL, s[7:0]);
            timestamp_input = 1;
            cyc(6);
            note("aux disabled", 8'h00);
            seen({7'h00, aux_out_pin});
            timestamp_input = 0;
        end
        // serializer restart stops the 16 UI clock, then it resumes
        frame(1'b0, `ADDR_AUX_OUTPUT_CONTROL, 8'h00);
        frame(1'b0, `ADDR_AUX_OUTPUT_CONTROL, 8'h80);
        serializer_reinit = 1;
        cyc(10);
        note("aux in reinit", 8'h00);
        seen({7'h00, aux_out_pin});
        serializer_reinit = 0;
        period(0, per);
        note("aux after reinit", 8'd16);
        seen(per);
        // pin mode: register selects ignored, config pins pick div 2
        frame(1'b0, `ADDR_PLL_PIN_OVERRIDE, 8'h3C);
        pll_enable_pin = 1;
        single_ended_ref_pin = 1;
        clock_config_pin_b = 1;
        cyc(6);
        note("pin pll enable", 8'h01);
        seen({7'h00, pll_enable});
        note("pin se ref", 8'h01);
        seen({7'h00, single_ended_ref_clock});
        period(1, per);
        note("pin C period", 8'd8);
        seen(per);
        period(2, per);
        note("pin D period", 8'd8);
        seen(per);
        // register mode over every C and D select pair
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 4; d++) begin
                v = 8'($random(seed));
                frame(1'b0, `ADDR_PLL_PIN_OVERRIDE, {2'h2, d[1:0], c[1:0], v[1:0]});
                note("reg pll enable", {7'h00, v[0]});
                seen({7'h00, pll_enable});
                note("reg se ref", {7'h00, v[1]});
                seen({7'h00, single_ended_ref_clock});
                period(1, per);
                note("C period", c == 0 ? 8'h00 : 8'd4 << (c - 1));
                seen(per);
                period(2, per);
                note("D period", (c == 0 || d == 0) ? 8'h00 : 8'd4 << (d - 1));
                seen(per);
            end
        end
        test_done();
    end

    // watchdog well past the longest expected run
    initial begin
        cyc(90000);
        bad_count++;
        test_done();
    end
endmodule

`default_nettype wire
